// ### core/pwr_seq_pkg.sv
// Summary of operation
// - idle request stops core clock; core state and port levels are held.
// - in idle timers, pwm timer and serial port stay clocked; comparator is off.
// - idle ends on enabled interrupt or reset; interrupt is serviced immediately.
// - power-down request stops oscillator and powers flash down; ram is retained.
// - power-down ends only on external reset, power-on, external interrupt, wake pin.
// - each of four external interrupts wakes only when enabled and level-sensitive.
// - third and fourth interrupt pins also wake only when enabled and level-sensitive.
// - exit mode zero: falling edge restarts oscillator, core clock after wake timer.
// - exit mode one: core clock withheld until the rising edge of that pin.
// - reset pin rising edge exits power-down; clock gated until timer full and reset drops.
// - reset ending idle blocks ram writes for up to two machine cycles.
// - reset loads registers, pulls pins weakly high, fetches 0000H or programming start.
// - four reset sources: reset pin, power-on, watchdog overflow, software request.
// - hardware clears power-down and idle request bits on any wake exit.
// - wake pin falling edge ends power-down internally timed, with no interrupt.
package pwr_seq_pkg;
    localparam int WAKE_TMR_W = 10;
    localparam int MACH_CYC = 12;
    localparam int HOLD_CYC = 2 * MACH_CYC;
    localparam int HOLD_W = 5;
    localparam int NUM_IRQ = 4;
    localparam int PD_GAP_NS = 4000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PD_GAP_CYC = (PD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W = 10;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] ISP_START_DEF = 16'hF000;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_IRQ,
        SRC_PIN,
        SRC_RST
    } wake_src_e;

    // software-facing control bits
    typedef struct packed {
        logic idle_request_bit;
        logic powerdown_request_bit;
        logic wake_exit_mode_bit;
        logic idle_clr;
        logic pd_clr;
    } pwr_ctrl_s;

    // interrupt wake configuration
    typedef struct packed {
        logic [NUM_IRQ-1:0] enable;
        logic [NUM_IRQ-1:0] level_mode;
    } irq_cfg_s;

    // clock and power gate outputs
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic flash_pwr_en;
        logic comparator_en;
        logic ram_wr_block;
    } pwr_gate_s;
endpackage : pwr_seq_pkg

// ### core/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // two-flop level synchroniser
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= INIT;
            q_r <= INIT;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
    assign q = q_r;
endmodule : sync2

// ### core/wake_timer.sv
`timescale 1ns/1ps
module wake_timer
    import pwr_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic run,
    output logic full
);
    logic [WAKE_TMR_W-1:0] cnt_r;
    logic [WAKE_TMR_W-1:0] cnt_nxt;
    logic full_r;
    logic full_nxt;

    // counter cleared at wake, fills on the restarted oscillator
    always_comb begin
        cnt_nxt = cnt_r;
        full_nxt = full_r;
        if (clear) begin
            cnt_nxt = '0;
            full_nxt = 1'b0;
        end else if (run && !full_r) begin
            cnt_nxt = cnt_r + 1'b1;
            full_nxt = &cnt_r; // terminal count
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
            full_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
        end
    end
    assign full = full_r;
endmodule : wake_timer

// ### core/idle_powerdown_wake_control.sv
`timescale 1ns/1ps
module idle_powerdown_wake_control
    import pwr_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire pwr_seq_pkg::pwr_ctrl_s ctrl,
    input wire pwr_seq_pkg::irq_cfg_s irq_cfg,
    input wire logic irq_pending,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_irq_c,
    input wire logic ext_irq_d,
    input wire logic [15:0] wake_pin,
    input wire logic [15:0] wake_pin_en,
    input wire logic ext_reset,
    input wire logic por_n,
    input wire logic watchdog_overflow,
    input wire logic sw_reset_req,
    input wire logic isp_boot_sel,
    input wire logic [15:0] isp_start_addr,
    output pwr_seq_pkg::pwr_gate_s gate,
    output logic idle_request_bit,
    output logic powerdown_request_bit,
    output logic core_reset,
    output logic ports_weak_pullup,
    output logic [15:0] fetch_addr,
    output logic wake_irq_service,
    output logic [1:0] last_wake_src,
    output logic pd_entry_allowed
);
    import pwr_seq_pkg::*;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_PD,
        ST_WAKE_TIMED,
        ST_WAKE_EXT,
        ST_RST_HOLD
    } pwr_state_e;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [NUM_IRQ-1:0] irq_s;
    logic [15:0] pin_s;
    logic rst_s;
    logic por_n_s;

    sync2 #(.W(NUM_IRQ), .INIT({NUM_IRQ{1'b1}})) u_sync_irq (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d({ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a}),
        .q(irq_s)
    );
    sync2 #(.W(16), .INIT(16'hFFFF)) u_sync_pin (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d(wake_pin),
        .q(pin_s)
    );
    sync2 #(.W(2), .INIT(2'h1)) u_sync_rst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d({ext_reset, por_n}),
        .q({rst_s, por_n_s})
    );

    // edge history of synchronised inputs
    logic [NUM_IRQ-1:0] irq_d_r;
    logic [15:0] pin_d_r;
    logic rst_d_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_d_r <= {NUM_IRQ{1'b1}};
            pin_d_r <= 16'hFFFF;
            rst_d_r <= 1'b0;
        end else begin
            irq_d_r <= irq_s;
            pin_d_r <= pin_s;
            rst_d_r <= rst_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake qualification
    logic [NUM_IRQ-1:0] irq_fall;
    logic [NUM_IRQ-1:0] irq_wake;
    logic pin_wake;
    logic rst_rise;
    logic any_reset;

    always_comb begin
        irq_fall = irq_d_r & ~irq_s;
        // only enabled, level-sensitive interrupts wake; c and d have no exception
        irq_wake = irq_fall & irq_cfg.enable & irq_cfg.level_mode;
        pin_wake = |(pin_d_r & ~pin_s & wake_pin_en);
        rst_rise = rst_s & ~rst_d_r;
        // every source gives a full reset
        any_reset = rst_s | ~por_n_s | watchdog_overflow | sw_reset_req;
    end

    ////////////////////////////////////////////////////////////////////////
    // power state machine
    pwr_state_e state_r, state_nxt;
    logic [1:0] irq_idx_r, irq_idx_nxt;
    wake_src_e src_r, src_nxt;
    logic idle_r, idle_nxt;
    logic pd_r, pd_nxt;
    logic svc_r, svc_nxt;
    logic tmr_clear;
    logic tmr_full;
    logic [HOLD_W-1:0] hold_r, hold_nxt;
    logic [GAP_W-1:0] gap_r, gap_nxt;
    logic idle_rst_r, idle_rst_nxt;

    // fills while the core waits on an internally timed wake
    wake_timer u_wake_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clear(tmr_clear),
        .run(state_r == ST_WAKE_TIMED),
        .full(tmr_full)
    );

    // lowest numbered waking interrupt; its pin ends an externally controlled wake
    function automatic logic [1:0] first_irq(input logic [NUM_IRQ-1:0] v);
        first_irq = 2'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_irq = 2'(i);
            end
        end
    endfunction : first_irq

    // next state, request bits and wake bookkeeping
    always_comb begin
        state_nxt = state_r;
        irq_idx_nxt = irq_idx_r;
        src_nxt = src_r;
        svc_nxt = 1'b0;
        tmr_clear = 1'b0;
        hold_nxt = hold_r;
        idle_rst_nxt = 1'b0;
        gap_nxt = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
        // set by software, cleared by software or any wake exit
        idle_nxt = (idle_r | ctrl.idle_request_bit) & ~ctrl.idle_clr;
        pd_nxt = (pd_r | (ctrl.powerdown_request_bit & gap_r == '0)) & ~ctrl.pd_clr;
        unique case (state_r)
            ST_RUN: begin
                if (pd_r) begin
                    state_nxt = ST_PD;
                end else if (idle_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (any_reset) begin
                    // core clock off, ram writes blocked briefly before reset asserts
                    idle_nxt = 1'b0;
                    state_nxt = ST_RST_HOLD;
                    hold_nxt = HOLD_W'(HOLD_CYC - 1);
                    idle_rst_nxt = 1'b1; // first blocked cycle, no reset pulse yet
                    src_nxt = SRC_RST;
                end else if (irq_pending) begin
                    idle_nxt = 1'b0;
                    svc_nxt = 1'b1;
                    state_nxt = ST_RUN;
                    src_nxt = SRC_IRQ;
                end
            end
            ST_PD: begin
                // only four causes leave power-down
                if (rst_rise || !por_n_s) begin
                    pd_nxt = 1'b0;
                    tmr_clear = 1'b1;
                    src_nxt = SRC_RST;
                    state_nxt = ST_WAKE_TIMED;
                end else if (|irq_wake) begin
                    pd_nxt = 1'b0;
                    tmr_clear = 1'b1;
                    src_nxt = SRC_IRQ;
                    irq_idx_nxt = first_irq(irq_wake);
                    state_nxt = ctrl.wake_exit_mode_bit ? ST_WAKE_EXT : ST_WAKE_TIMED;
                end else if (pin_wake) begin
                    pd_nxt = 1'b0;
                    tmr_clear = 1'b1;
                    src_nxt = SRC_PIN;
                    state_nxt = ST_WAKE_TIMED;
                end
            end
            ST_WAKE_TIMED: begin
                if (tmr_full) begin
                    // clock released at timer full, or reset hold entered for a reset wake
                    state_nxt = (src_r == SRC_RST) ? ST_RST_HOLD : ST_RUN;
                    hold_nxt = '0;
                    svc_nxt = (src_r == SRC_IRQ);
                    gap_nxt = GAP_W'(PD_GAP_CYC);
                end
            end
            ST_WAKE_EXT: begin
                // hold the core clock until that pin rises again
                if (irq_s[irq_idx_r] && !irq_d_r[irq_idx_r]) begin
                    state_nxt = ST_RUN; // rising edge releases clock
                    svc_nxt = 1'b1;
                    gap_nxt = GAP_W'(PD_GAP_CYC);
                end
            end
            ST_RST_HOLD: begin
                if (hold_r != '0) begin
                    hold_nxt = hold_r - 1'b1;
                    idle_rst_nxt = 1'b1;
                end else if (!any_reset) begin
                    state_nxt = ST_RUN; // execute once reset drops
                    gap_nxt = GAP_W'(PD_GAP_CYC);
                end
            end
            default: begin
                state_nxt = ST_RST_HOLD; // illegal code recovers through reset hold
            end
        endcase
        // a reset while running or already held takes over at once; idle runs on first
        if (any_reset && state_r != ST_PD && state_r != ST_IDLE && state_r != ST_WAKE_TIMED) begin
            if (state_r != ST_RST_HOLD) begin
                state_nxt = ST_RST_HOLD;
                hold_nxt = '0;
            end
            idle_nxt = 1'b0;
            pd_nxt = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RST_HOLD;
            irq_idx_r <= 2'h0;
            src_r <= SRC_NONE;
            idle_r <= 1'b0;
            pd_r <= 1'b0;
            svc_r <= 1'b0;
            hold_r <= '0;
            gap_r <= '0;
            idle_rst_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            irq_idx_r <= irq_idx_nxt;
            src_r <= src_nxt;
            idle_r <= idle_nxt;
            pd_r <= pd_nxt;
            svc_r <= svc_nxt;
            hold_r <= hold_nxt;
            gap_r <= gap_nxt;
            idle_rst_r <= idle_rst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    pwr_gate_s gate_r, gate_nxt;
    logic reset_r, pull_r;
    logic [15:0] fetch_r;
    logic pd_ok_r;

    // gate values follow the next state so outputs switch with it
    always_comb begin
        gate_nxt.core_clk_en = (state_nxt == ST_RUN);
        gate_nxt.periph_clk_en = (state_nxt == ST_RUN || state_nxt == ST_IDLE);
        gate_nxt.osc_en = (state_nxt != ST_PD);
        gate_nxt.flash_pwr_en = (state_nxt != ST_PD);
        gate_nxt.comparator_en = (state_nxt == ST_RUN);
        gate_nxt.ram_wr_block = idle_rst_nxt;
    end

    // output flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_r <= '0;
            reset_r <= 1'b1;
            pull_r <= 1'b1;
            fetch_r <= RESET_VECTOR;
            pd_ok_r <= 1'b1;
        end else begin
            gate_r <= gate_nxt;
            pd_ok_r <= (gap_nxt == '0);
            reset_r <= (state_nxt == ST_RST_HOLD) && !idle_rst_nxt;
            pull_r <= (state_nxt == ST_RST_HOLD);
            fetch_r <= isp_boot_sel ? isp_start_addr : RESET_VECTOR;
        end
    end

    // ports straight from flops
    assign gate = gate_r;
    assign idle_request_bit = idle_r;
    assign powerdown_request_bit = pd_r;
    assign core_reset = reset_r;
    assign ports_weak_pullup = pull_r;
    assign fetch_addr = fetch_r;
    assign wake_irq_service = svc_r;
    assign last_wake_src = src_r;
    assign pd_entry_allowed = pd_ok_r;
endmodule : idle_powerdown_wake_control

// ### bench/pwr_wake_monitor.sv
`timescale 1ns/1ps
module pwr_wake_monitor (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic irq_pending,
    input wire logic watchdog_overflow,
    input wire logic sw_reset_req,
    input wire pwr_seq_pkg::pwr_gate_s gate,
    input wire logic idle_request_bit,
    input wire logic powerdown_request_bit,
    input wire logic core_reset,
    input wire logic ports_weak_pullup,
    input wire logic wake_irq_service,
    input wire logic pd_entry_allowed
);
    import pwr_seq_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // ram writes stay blocked for a while before reset takes over
    sequence s_blk;
        gate.ram_wr_block [*8];
    endsequence
    property p_idle_gate;
        $rose(idle_request_bit) |-> ##1 !gate.core_clk_en;
    endproperty
    property p_idle_periph;
        idle_request_bit && !gate.ram_wr_block && !core_reset |-> gate.periph_clk_en;
    endproperty
    property p_idle_cmp;
        idle_request_bit [*2] |-> !gate.comparator_en;
    endproperty
    property p_idle_exit;
        idle_request_bit && irq_pending |=> !idle_request_bit ##[0:1] gate.core_clk_en;
    endproperty
    property p_pd_gate;
        $rose(powerdown_request_bit) |-> ##[1:2] (!gate.osc_en && !gate.flash_pwr_en);
    endproperty
    property p_pd_hold;
        $fell(powerdown_request_bit) |-> !gate.core_clk_en [*8];
    endproperty
    property p_gap;
        $rose(powerdown_request_bit) |-> $past(pd_entry_allowed);
    endproperty
    property p_rst_out;
        core_reset |-> ports_weak_pullup && !gate.core_clk_en;
    endproperty
    property p_src;
        (watchdog_overflow || sw_reset_req) && gate.core_clk_en |-> ##[1:4] core_reset;
    endproperty
    property p_blk;
        $rose(gate.ram_wr_block) |-> s_blk ##[1:30] core_reset;
    endproperty
    property p_svc;
        wake_irq_service |=> !wake_irq_service;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("core clock in idle");
    a_idle_periph: assert property (p_idle_periph) else $error("periph off");
    a_idle_cmp: assert property (p_idle_cmp) else $error("comparator on");
    a_idle_exit: assert property (p_idle_exit) else $error("idle kept");
    a_pd_gate: assert property (p_pd_gate) else $error("osc on");
    a_pd_hold: assert property (p_pd_hold) else $error("clock early");
    a_gap: assert property (p_gap) else $error("gap ignored");
    a_rst_out: assert property (p_rst_out) else $error("reset outs");
    a_src: assert property (p_src) else $error("no reset");
    a_blk: assert property (p_blk) else $error("ram block");
    a_svc: assert property (p_svc) else $error("long pulse");
endmodule : pwr_wake_monitor
bind idle_powerdown_wake_control pwr_wake_monitor mon_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .irq_pending(irq_pending), .watchdog_overflow(watchdog_overflow),
    .sw_reset_req(sw_reset_req), .gate(gate), .idle_request_bit(idle_request_bit),
    .powerdown_request_bit(powerdown_request_bit), .core_reset(core_reset),
    .ports_weak_pullup(ports_weak_pullup), .wake_irq_service(wake_irq_service),
    .pd_entry_allowed(pd_entry_allowed));

// ### bench/wake_partner.sv
`timescale 1ns/1ps
module wake_partner (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic [2:0] line,
    input wire logic [31:0] hold,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic ext_irq_c,
    output logic ext_irq_d,
    output logic [15:0] wake_pin,
    output logic ext_reset
);
    logic [3:0] irq_n;
    assign ext_irq_a = irq_n[0];
    assign ext_irq_b = irq_n[1];
    assign ext_irq_c = irq_n[2];
    assign ext_irq_d = irq_n[3];
    // one wake stimulus per request; pins idle high, reset idle low
    initial begin
        irq_n = 4'hF;
        wake_pin = 16'hFFFF;
        ext_reset = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (fire === 1'b1) begin
                if (line == 3'h4)
                    ext_reset <= 1'b1;
                else if (line == 3'h5)
                    wake_pin[0] <= 1'b0;
                else
                    irq_n[line[1:0]] <= 1'b0;
                repeat (hold) @(posedge ref_clk);
                irq_n <= 4'hF;
                wake_pin <= 16'hFFFF;
                ext_reset <= 1'b0;
            end
        end
    end
endmodule : wake_partner

// ### bench/idle_powerdown_wake_control_bench.sv
`timescale 1ns/1ps
module idle_powerdown_wake_control_bench;
    import pwr_seq_pkg::*;
    logic ref_clk, reset_n, irq_pending, ext_reset, por_n, watchdog_overflow, sw_reset_req;
    logic isp_boot_sel, fire, svc_seen, ext_irq_a, ext_irq_b, ext_irq_c, ext_irq_d;
    logic idle_request_bit, powerdown_request_bit, core_reset, ports_weak_pullup;
    logic wake_irq_service, pd_entry_allowed;
    logic [15:0] wake_pin, wake_pin_en, isp_start_addr, fetch_addr;
    logic [1:0] last_wake_src;
    logic [2:0] line;
    pwr_ctrl_s ctrl;
    irq_cfg_s irq_cfg;
    pwr_gate_s gate;
    int hold, mismatches, compares, n;
    idle_powerdown_wake_control dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl(ctrl),
        .irq_cfg(irq_cfg), .irq_pending(irq_pending), .ext_irq_a(ext_irq_a),
        .ext_irq_b(ext_irq_b), .ext_irq_c(ext_irq_c), .ext_irq_d(ext_irq_d),
        .wake_pin(wake_pin), .wake_pin_en(wake_pin_en), .ext_reset(ext_reset), .por_n(por_n),
        .watchdog_overflow(watchdog_overflow), .sw_reset_req(sw_reset_req),
        .isp_boot_sel(isp_boot_sel), .isp_start_addr(isp_start_addr), .gate(gate),
        .idle_request_bit(idle_request_bit), .powerdown_request_bit(powerdown_request_bit),
        .core_reset(core_reset), .ports_weak_pullup(ports_weak_pullup),
        .fetch_addr(fetch_addr), .wake_irq_service(wake_irq_service),
        .last_wake_src(last_wake_src), .pd_entry_allowed(pd_entry_allowed));
    wake_partner far_u (.ref_clk(ref_clk), .fire(fire), .line(line), .hold(hold),
        .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .ext_irq_c(ext_irq_c),
        .ext_irq_d(ext_irq_d), .wake_pin(wake_pin), .ext_reset(ext_reset));
    ////////////////////////////////////////////////////////////////
    // clock and sticky capture of the one-cycle service pulse
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (wake_irq_service === 1'b1)
            svc_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    function automatic logic sig(input int s);
        return s == 0 ? gate.core_clk_en : s == 1 ? pd_entry_allowed :
            s == 2 ? !core_reset : core_reset;
    endfunction : sig
    // bounded wait for core clock, pd permission, reset end or reset start
    task automatic wait_hi(input int s, output int c);
        c = 0;
        while (sig(s) !== 1'b1) begin
            @(posedge ref_clk);
            c++;
            if (c > 3000) begin
                mismatches++;
                tally_and_finish();
            end
        end
    endtask : wait_hi
    task automatic req(input logic pd);
        @(posedge ref_clk);
        ctrl.powerdown_request_bit <= pd;
        ctrl.idle_request_bit <= !pd;
        @(posedge ref_clk);
        ctrl.powerdown_request_bit <= 1'b0;
        ctrl.idle_request_bit <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : req
    task automatic fire_line(input logic [2:0] l, input int h);
        @(posedge ref_clk);
        line <= l;
        hold <= h;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
    endtask : fire_line
    ////////////////////////////////////////////////////////////////
    initial begin
        ctrl = '0;
        irq_cfg = '0;
        {irq_pending, watchdog_overflow, sw_reset_req, isp_boot_sel, fire, svc_seen} = '0;
        {por_n, reset_n} = 2'h2;
        isp_start_addr = 16'h1234;
        wake_pin_en = 16'h0000;
        line = 3'h0;
        hold = 1;
        mismatches = 0;
        compares = 0;
        repeat (6) @(posedge ref_clk);
        check(core_reset, 1'b1);
        check(ports_weak_pullup, 1'b1);
        reset_n <= 1'b1;
        wait_hi(2, n);
        check(fetch_addr, RESET_VECTOR);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            watchdog_overflow <= (i == 0);
            sw_reset_req <= (i == 1);
            por_n <= (i != 2);
            isp_boot_sel <= (i == 2);
            repeat (4) @(posedge ref_clk);
            check(core_reset, 1'b1);
            {watchdog_overflow, sw_reset_req, por_n} <= 3'h1;
            wait_hi(2, n);
        end
        check(fetch_addr, 16'h1234);
        $display("reset test done");
        req(1'b0);
        check(idle_request_bit, 1'b1);
        check(gate.core_clk_en, 1'b0);
        check(gate.periph_clk_en, 1'b1);
        check(gate.comparator_en, 1'b0);
        irq_pending <= 1'b1;
        repeat (3) @(posedge ref_clk);
        irq_pending <= 1'b0;
        check(idle_request_bit, 1'b0);
        check({gate.core_clk_en, svc_seen}, 2'h3);
        $display("idle test done");
        for (int i = 0; i < 4; i++) begin
            irq_cfg.enable <= 4'(1 << i);
            irq_cfg.level_mode <= ~4'(1 << i);
            wait_hi(1, n);
            req(1'b1);
            check({gate.osc_en, gate.flash_pwr_en}, 2'h0);
            fire_line(3'((i + 1) % 4), 40);
            repeat (60) @(posedge ref_clk);
            fire_line(3'(i), 40);
            repeat (60) @(posedge ref_clk);
            check(gate.osc_en, 1'b0);
            irq_cfg.level_mode <= 4'hF;
            svc_seen = 1'b0;
            fire_line(3'(i), 1100);
            wait_hi(0, n);
            repeat (3) @(posedge ref_clk);
            check(n >= (1 << WAKE_TMR_W), 1'b1);
            check({last_wake_src, svc_seen}, {SRC_IRQ, 1'b1});
            check({powerdown_request_bit, pd_entry_allowed}, 2'h0);
        end
        $display("irq wake test done");
        irq_cfg.enable <= 4'h1;
        ctrl.wake_exit_mode_bit <= 1'b1;
        wait_hi(1, n);
        req(1'b1);
        fire_line(3'h0, 200);
        repeat (150) @(posedge ref_clk);
        check({gate.osc_en, gate.core_clk_en}, 2'h2);
        wait_hi(0, n);
        check(n > 40 && n < 70, 1'b1);
        ctrl.wake_exit_mode_bit <= 1'b0;
        irq_cfg.enable <= 4'h0;
        wake_pin_en <= 16'h0001;
        wait_hi(1, n);
        req(1'b1);
        svc_seen = 1'b0;
        fire_line(3'h5, 1100);
        wait_hi(0, n);
        repeat (3) @(posedge ref_clk);
        check({last_wake_src, svc_seen}, {SRC_PIN, 1'b0});
        check(n >= (1 << WAKE_TMR_W), 1'b1);
        $display("mode and pin wake test done");
        wait_hi(1, n);
        req(1'b1);
        fire_line(3'h4, 1100);
        repeat (100) @(posedge ref_clk);
        check({gate.osc_en, gate.core_clk_en, core_reset}, 3'h4);
        wait_hi(3, n);
        check(n > 900, 1'b1);
        wait_hi(0, n);
        check(last_wake_src, SRC_RST);
        req(1'b0);
        fire_line(3'h4, 80);
        n = 0;
        repeat (60) @(posedge ref_clk) n += (gate.ram_wr_block === 1'b1 && !core_reset);
        check(n, HOLD_CYC);
        check(core_reset, 1'b1);
        wait_hi(2, n);
        $display("reset wake test done");
        tally_and_finish();
    end
endmodule : idle_powerdown_wake_control_bench
